// ==== rtl/adc10_channel_trigger_ctrl.sv ====
// control of a single 10-bit converter unit: channel, mode, trigger, results
// assumes a converter core that takes a one-cycle request and answers done
//
// Contract
// - single mode converts the input numbered by the channel field, then the extended input when enabled.
// - scan mode converts inputs zero up to the channel field in order.
// - trigger codes 0-3 pick software, timer 0-4 A, 8-bit timer 0, pin.
// - codes 4-7 pick timer0 A, pulse timers 0-4 A, timer4 match, pulse0 A.
// - one unit serves eight analog inputs plus one extended input.
// - each input's result lands in its own result register, A to H, or the extended result register.
//
// Implementation choices: the address-and-strobe port and the register addresses.
module adc10_channel_trigger_ctrl (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    // register port
    input wire adc10_pkg::bus_req_t busReq,
    output logic [adc10_pkg::DATA_W-1:0] rdData,
    // trigger sources
    input wire adc10_pkg::trig_events_t trigEv,
    // converter core
    output adc10_pkg::conv_req_t convReq,
    input wire adc10_pkg::conv_rsp_t convRsp,
    output logic [1:0] convClkSel,
    // interrupt
    output logic irq
);

    // control registers and sequencer
    logic [2:0] chanSel_q, chanSel_d;
    logic startBit_q, startBit_d;
    logic irqEn_q, irqEn_d;
    logic [1:0] mode_q, mode_d;
    logic [1:0] clkSel_q, clkSel_d;
    adc10_pkg::trig_sel_t trigSel_q, trigSel_d;
    logic extEn_q, extEn_d;
    adc10_pkg::seq_state_t state_q, state_d;
    logic [3:0] curChan_q, curChan_d;
    adc10_pkg::conv_req_t convReq_q, convReq_d;

    // status, mask, read port
    logic [1:0] irqStat_q, irqStat_d;
    logic [1:0] irqMask_q, irqMask_d;
    logic irq_q, irq_d;
    logic [adc10_pkg::DATA_W-1:0] rdData_q, rdData_d;

    logic hwTrig, swStart, abortWr, endEvt, lostEvt, resWr;
    logic moreScan, needExt, rdStat;
    logic [1:0] irqSet;
    logic [3:0] rdSlot;
    logic [adc10_pkg::RES_W-1:0] bankData;
    logic [adc10_pkg::DATA_W-1:0] wd;

    adc10_trigger_select u_trig (
        .sys_clk(sys_clk),
        .srst(srst),
        .ce(ce),
        .trigSel(trigSel_q),
        .trigEv(trigEv),
        .hwTrig(hwTrig)
    );

    adc10_result_bank u_bank (
        .sys_clk(sys_clk),
        .srst(srst),
        .ce(ce),
        .wrEn(resWr),
        .wrSlot(curChan_q),
        .wrData(convRsp.data),
        .rdSlot(rdSlot),
        .rdData(bankData)
    );

    always_comb begin
        chanSel_d = chanSel_q;
        startBit_d = startBit_q;
        irqEn_d = irqEn_q;
        mode_d = mode_q;
        clkSel_d = clkSel_q;
        trigSel_d = trigSel_q;
        extEn_d = extEn_q;
        state_d = state_q;
        curChan_d = curChan_q;
        convReq_d = '0;
        swStart = 1'b0;
        abortWr = 1'b0;
        endEvt = 1'b0;
        resWr = 1'b0;
        wd = busReq.wdata;
        if (busReq.wr) begin
            if (busReq.addr == adc10_pkg::OFF_CSR) begin
                irqEn_d = wd[adc10_pkg::CSR_IE_BIT];
                // channel field frozen while a conversion runs
                if (!startBit_q) begin
                    chanSel_d = wd[adc10_pkg::CSR_CHAN_LSB +: 3];
                end
                if (wd[adc10_pkg::CSR_START_BIT]) begin
                    swStart = !startBit_q;
                end else begin
                    abortWr = startBit_q;
                end
            end else if (busReq.addr == adc10_pkg::OFF_CR) begin
                mode_d = wd[adc10_pkg::CR_MODE_LSB +: 2];
                clkSel_d = wd[adc10_pkg::CR_CLK_LSB +: 2];
                trigSel_d = adc10_pkg::trig_sel_t'(
                    wd[adc10_pkg::CR_TRIG_LSB +: 3]);
            end else if (busReq.addr == adc10_pkg::OFF_EXT_CTRL) begin
                extEn_d = wd[adc10_pkg::EXT_EN_BIT];
            end
        end
        lostEvt = hwTrig && startBit_q;
        moreScan = mode_q != adc10_pkg::MODE_SINGLE && !curChan_q[3]
            && curChan_q[2:0] < chanSel_q;
        needExt = extEn_q && !curChan_q[3];
        case (state_q)
            adc10_pkg::ST_IDLE: begin
                if (swStart || (hwTrig && !startBit_q)) begin
                    startBit_d = 1'b1;
                    state_d = adc10_pkg::ST_ISSUE;
                    if (mode_q == adc10_pkg::MODE_SINGLE) begin
                        curChan_d = {1'b0, chanSel_d};
                    end else begin
                        curChan_d = 4'h0;
                    end
                end
            end
            adc10_pkg::ST_ISSUE: begin
                convReq_d.valid = 1'b1;
                convReq_d.chan = curChan_q;
                state_d = adc10_pkg::ST_WAIT;
            end
            adc10_pkg::ST_WAIT: begin
                if (convRsp.done) begin
                    resWr = 1'b1;
                    if (moreScan) begin
                        curChan_d = curChan_q + 4'h1;
                        state_d = adc10_pkg::ST_ISSUE;
                    end else if (needExt) begin
                        curChan_d = adc10_pkg::EXT_CHAN;
                        state_d = adc10_pkg::ST_ISSUE;
                    end else begin
                        startBit_d = 1'b0;
                        state_d = adc10_pkg::ST_IDLE;
                        endEvt = 1'b1;
                    end
                end
            end
            default: begin
                state_d = adc10_pkg::ST_IDLE;
            end
        endcase
        // writing zero to the start bit stops the sequence at once
        if (abortWr) begin
            startBit_d = 1'b0;
            state_d = adc10_pkg::ST_IDLE;
            endEvt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chanSel_q <= adc10_pkg::CSR_RST[2:0];
            startBit_q <= adc10_pkg::CSR_RST[5];
            irqEn_q <= adc10_pkg::CSR_RST[6];
            mode_q <= adc10_pkg::CR_RST[1:0];
            clkSel_q <= adc10_pkg::CR_RST[3:2];
            trigSel_q <= adc10_pkg::TRG_SOFT;
            extEn_q <= adc10_pkg::EXT_EN_RST;
            state_q <= adc10_pkg::ST_IDLE;
            curChan_q <= 4'h0;
            convReq_q <= '0;
        end else if (ce) begin
            chanSel_q <= chanSel_d;
            startBit_q <= startBit_d;
            irqEn_q <= irqEn_d;
            mode_q <= mode_d;
            clkSel_q <= clkSel_d;
            trigSel_q <= trigSel_d;
            extEn_q <= extEn_d;
            state_q <= state_d;
            curChan_q <= curChan_d;
            convReq_q <= convReq_d;
        end
    end

    always_comb begin
        rdStat = busReq.rd && busReq.addr == adc10_pkg::OFF_IRQ_STAT;
        irqSet = '0;
        irqSet[adc10_pkg::IRQ_END_BIT] = endEvt && irqEn_q;
        irqSet[adc10_pkg::IRQ_LOST_BIT] = lostEvt;
        // a new event in the clearing read survives
        irqStat_d = (irqStat_q & {2{!rdStat}}) | irqSet;
        irqMask_d = irqMask_q;
        if (busReq.wr && busReq.addr == adc10_pkg::OFF_IRQ_MASK) begin
            irqMask_d = busReq.wdata[1:0];
        end
        irq_d = |(irqStat_d & irqMask_d);
        if (busReq.addr == adc10_pkg::OFF_RES_EXT) begin
            rdSlot = adc10_pkg::EXT_CHAN;
        end else begin
            rdSlot = busReq.addr - adc10_pkg::OFF_RES_A;
        end
        rdData_d = '0;
        if (busReq.rd) begin
            if (busReq.addr == adc10_pkg::OFF_CSR) begin
                rdData_d = {9'h000, irqEn_q, startBit_q, 2'h0, chanSel_q};
            end else if (busReq.addr == adc10_pkg::OFF_CR) begin
                rdData_d = {8'h00, trigSel_q, 1'b0, clkSel_q, mode_q};
            end else if (busReq.addr >= adc10_pkg::OFF_RES_A
                    && busReq.addr <= adc10_pkg::OFF_RES_H) begin
                rdData_d = {6'h00, bankData};
            end else if (busReq.addr == adc10_pkg::OFF_RES_EXT) begin
                rdData_d = {6'h00, bankData};
            end else if (busReq.addr == adc10_pkg::OFF_IRQ_STAT) begin
                rdData_d = {14'h0000, irqStat_q};
            end else if (busReq.addr == adc10_pkg::OFF_IRQ_MASK) begin
                rdData_d = {14'h0000, irqMask_q};
            end else if (busReq.addr == adc10_pkg::OFF_EXT_CTRL) begin
                rdData_d = {15'h0000, extEn_q};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irqStat_q <= 2'h0;
            irqMask_q <= adc10_pkg::IRQ_MASK_RST;
            irq_q <= 1'b0;
            rdData_q <= '0;
        end else if (ce) begin
            irqStat_q <= irqStat_d;
            irqMask_q <= irqMask_d;
            irq_q <= irq_d;
            rdData_q <= rdData_d;
        end
    end

    assign rdData = rdData_q;
    assign convReq = convReq_q;
    assign convClkSel = clkSel_q;
    assign irq = irq_q;

    property p_single_chan;
        @(posedge sys_clk) disable iff (srst || !ce)
        convReq_q.valid && mode_q == adc10_pkg::MODE_SINGLE
            && convReq_q.chan != adc10_pkg::EXT_CHAN
            |-> convReq_q.chan == {1'b0, chanSel_q};
    endproperty
    a_single_chan: assert property (p_single_chan)
        else $error("single mode converted a wrong input");

    property p_scan_next;
        @(posedge sys_clk) disable iff (srst || !ce)
        state_q == adc10_pkg::ST_WAIT && convRsp.done && moreScan && !abortWr
            |-> ##2 convReq_q.valid
                && convReq_q.chan == $past(curChan_q, 2) + 4'h1;
    endproperty
    a_scan_next: assert property (p_scan_next)
        else $error("scan did not step to the next input");

    property p_ext_last;
        @(posedge sys_clk) disable iff (srst || !ce)
        $fell(startBit_q) && $past(extEn_q) && !$past(abortWr)
            |-> $past(curChan_q) == adc10_pkg::EXT_CHAN;
    endproperty
    a_ext_last: assert property (p_ext_last)
        else $error("extended input skipped");

    property p_end_irq;
        @(posedge sys_clk) disable iff (srst || !ce)
        state_q == adc10_pkg::ST_WAIT && convRsp.done && !moreScan
            && !needExt && !abortWr && irqEn_q
            |=> !startBit_q && irqStat_q[adc10_pkg::IRQ_END_BIT];
    endproperty
    a_end_irq: assert property (p_end_irq)
        else $error("end of conversion not flagged");

    property p_scan_first;
        @(posedge sys_clk) disable iff (srst || !ce)
        $rose(startBit_q) && mode_q != adc10_pkg::MODE_SINGLE
            |=> convReq_q.valid && convReq_q.chan == 4'h0;
    endproperty
    a_scan_first: assert property (p_scan_first)
        else $error("scan did not begin at input zero");

    // scan must stop on the input named by the channel field
    property p_scan_stop;
        @(posedge sys_clk) disable iff (srst || !ce)
        state_q == adc10_pkg::ST_WAIT && convRsp.done
            && mode_q != adc10_pkg::MODE_SINGLE && !extEn_q && !abortWr
            && curChan_q == {1'b0, chanSel_q}
            |=> !startBit_q && state_q == adc10_pkg::ST_IDLE;
    endproperty
    a_scan_stop: assert property (p_scan_stop)
        else $error("scan ran past the channel field");

    property p_hw_start;
        @(posedge sys_clk) disable iff (srst || !ce)
        state_q == adc10_pkg::ST_IDLE && hwTrig && !startBit_q
            |=> startBit_q;
    endproperty
    a_hw_start: assert property (p_hw_start)
        else $error("selected trigger did not start");

    // hwTrig lags the code by one cycle, hence the past term
    property p_soft_quiet;
        @(posedge sys_clk) disable iff (srst || !ce)
        trigSel_q == adc10_pkg::TRG_SOFT
            && $past(trigSel_q) == adc10_pkg::TRG_SOFT |-> !hwTrig;
    endproperty
    a_soft_quiet: assert property (p_soft_quiet)
        else $error("hardware start under software trigger");

endmodule

// ==== rtl/adc10_pkg.sv ====
// shared constants, types and register map of the 10-bit converter control
// assumes one clock domain; register port offsets are word indices
package adc10_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned RES_W = 10;
    localparam int unsigned NUM_CHAN = 8;
    localparam int unsigned NUM_SLOT = 9;

    // register offsets on the plain register port
    localparam logic [3:0] OFF_CSR = 4'h0;
    localparam logic [3:0] OFF_CR = 4'h1;
    localparam logic [3:0] OFF_RES_A = 4'h2;
    localparam logic [3:0] OFF_RES_H = 4'h9;
    localparam logic [3:0] OFF_IRQ_STAT = 4'ha;
    localparam logic [3:0] OFF_IRQ_MASK = 4'hb;
    localparam logic [3:0] OFF_EXT_CTRL = 4'hc;
    localparam logic [3:0] OFF_RES_EXT = 4'hd;

    // field positions
    localparam int unsigned CSR_CHAN_LSB = 0;
    localparam int unsigned CSR_START_BIT = 5;
    localparam int unsigned CSR_IE_BIT = 6;
    localparam int unsigned CR_MODE_LSB = 0;
    localparam int unsigned CR_CLK_LSB = 2;
    localparam int unsigned CR_TRIG_LSB = 5;
    localparam int unsigned EXT_EN_BIT = 0;
    localparam int unsigned IRQ_END_BIT = 0;
    localparam int unsigned IRQ_LOST_BIT = 1;

    // reset values
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [7:0] CR_RST = 8'h00;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    localparam logic EXT_EN_RST = 1'b0;

    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [3:0] EXT_CHAN = 4'h8;

    typedef enum logic [2:0] {
        TRG_SOFT = 3'b000,
        TRG_MF_ANY_A = 3'b001,
        TRG_EIGHT0_CM = 3'b010,
        TRG_PIN = 3'b011,
        TRG_MF0_A = 3'b100,
        TRG_PU_ANY_A = 3'b101,
        TRG_MF4_CM = 3'b110,
        TRG_PU0_A = 3'b111
    } trig_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic [4:0] mfTimerCmpA;
        logic mfTimer4Cmp;
        logic eightTimer0Cmp;
        logic [4:0] puTimerCmpA;
        logic extTrigPinN;
    } trig_events_t;

    typedef struct packed {
        logic valid;
        logic [3:0] chan;
    } conv_req_t;

    typedef struct packed {
        logic done;
        logic [RES_W-1:0] data;
    } conv_rsp_t;

endpackage

// ==== rtl/adc10_result_bank.sv ====
// per-channel result registers: eight inputs plus the extended input
// assumes one write at most per cycle from the sequencer
module adc10_result_bank (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    // write side
    input wire logic wrEn,
    input wire logic [3:0] wrSlot,
    input wire logic [adc10_pkg::RES_W-1:0] wrData,
    // read side
    input wire logic [3:0] rdSlot,
    output logic [adc10_pkg::RES_W-1:0] rdData
);

    logic [adc10_pkg::RES_W-1:0] slotVal [adc10_pkg::NUM_SLOT];

    for (genvar i = 0; i < adc10_pkg::NUM_SLOT; i++) begin : g_slot
        logic [adc10_pkg::RES_W-1:0] slot_q, slot_d;

        always_comb begin
            slot_d = slot_q;
            if (wrEn && wrSlot == 4'(i)) begin
                slot_d = wrData;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (srst) begin
                slot_q <= '0;
            end else if (ce) begin
                slot_q <= slot_d;
            end
        end

        assign slotVal[i] = slot_q;

        property p_store;
            @(posedge sys_clk) disable iff (srst || !ce)
            wrEn && wrSlot == 4'(i) |=> slot_q == $past(wrData);
        endproperty
        a_store: assert property (p_store)
            else $error("result not stored in its own slot");
    end

    always_comb begin
        if (rdSlot < 4'(adc10_pkg::NUM_SLOT)) begin
            rdData = slotVal[rdSlot];
        end else begin
            rdData = '0;
        end
    end

endmodule

// ==== rtl/adc10_trigger_select.sv ====
// start-trigger selector: picks one hardware source and emits a start pulse
// assumes timer events are one-cycle pulses, pin synchronous and active low
module adc10_trigger_select (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    // selection and sources
    input wire adc10_pkg::trig_sel_t trigSel,
    input wire adc10_pkg::trig_events_t trigEv,
    // start pulse
    output logic hwTrig
);

    logic pinPrev_q, pinPrev_d;
    logic hwTrig_q, hwTrig_d;
    logic pinFall;

    always_comb begin
        pinPrev_d = trigEv.extTrigPinN;
        pinFall = pinPrev_q && !trigEv.extTrigPinN;
        case (trigSel)
            adc10_pkg::TRG_SOFT: hwTrig_d = 1'b0;
            adc10_pkg::TRG_MF_ANY_A: hwTrig_d = |trigEv.mfTimerCmpA;
            adc10_pkg::TRG_EIGHT0_CM: hwTrig_d = trigEv.eightTimer0Cmp;
            adc10_pkg::TRG_PIN: hwTrig_d = pinFall;
            adc10_pkg::TRG_MF0_A: hwTrig_d = trigEv.mfTimerCmpA[0];
            adc10_pkg::TRG_PU_ANY_A: hwTrig_d = |trigEv.puTimerCmpA;
            adc10_pkg::TRG_MF4_CM: hwTrig_d = trigEv.mfTimer4Cmp;
            adc10_pkg::TRG_PU0_A: hwTrig_d = trigEv.puTimerCmpA[0];
            default: hwTrig_d = 1'b0;
        endcase
    end

    // pin idles high, so reset prev high to avoid a false edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pinPrev_q <= 1'b1;
            hwTrig_q <= 1'b0;
        end else if (ce) begin
            pinPrev_q <= pinPrev_d;
            hwTrig_q <= hwTrig_d;
        end
    end

    assign hwTrig = hwTrig_q;

    property p_pin_start;
        @(posedge sys_clk) disable iff (srst || !ce)
        trigSel == adc10_pkg::TRG_PIN && pinPrev_q && !trigEv.extTrigPinN
            |=> hwTrig_q;
    endproperty
    a_pin_start: assert property (p_pin_start)
        else $error("pin falling edge gave no start");

    property p_pu_any;
        @(posedge sys_clk) disable iff (srst || !ce)
        trigSel == adc10_pkg::TRG_PU_ANY_A && (|trigEv.puTimerCmpA)
            |=> hwTrig_q;
    endproperty
    a_pu_any: assert property (p_pu_any)
        else $error("pulse unit event gave no start");

endmodule

// ==== tb/conv_core_model.sv ====
// behavioural converter core answering each request after a set latency
// assumes one request outstanding; result is built from salt and channel
module conv_core_model (
    // clock, reset
    input wire logic sys_clk,
    input wire logic srst,
    // request and answer
    input wire adc10_pkg::conv_req_t convReq,
    output adc10_pkg::conv_rsp_t convRsp,
    // latency and result salt chosen by the bench
    input wire logic [7:0] lat,
    input wire logic [5:0] salt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    logic [3:0] chan_q;
    always_ff @(posedge sys_clk) begin
        convRsp.done <= 1'h0;
        // data toggles outside done so a stale result is never mistaken
        convRsp.data <= ~convRsp.data;
        if (srst) begin
            cnt_q <= 8'h00;
            convRsp.data <= 10'h000;
        end else if (convReq.valid) begin
            cnt_q <= lat + 8'h01;
            chan_q <= convReq.chan;
        end else if (cnt_q == 8'h01) begin
            cnt_q <= 8'h00;
            convRsp.done <= 1'h1;
            convRsp.data <= {salt, chan_q};
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the converter control block
// assumes the converter model in conv_core_model; single clock domain
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [12:0] IDLE = 13'h0001;
    logic sys_clk, srst, ce, irq;
    adc10_pkg::bus_req_t busReq;
    logic [15:0] rdData;
    adc10_pkg::trig_events_t trigEv;
    adc10_pkg::conv_req_t convReq;
    adc10_pkg::conv_rsp_t convRsp;
    logic [1:0] convClkSel;
    logic [7:0] lat;
    logic [5:0] salt;
    logic [3:0] reqQ[$];
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    adc10_channel_trigger_ctrl adc10_channel_trigger_ctrl_i (
        .sys_clk(sys_clk), .srst(srst), .ce(ce), .busReq(busReq),
        .rdData(rdData), .trigEv(trigEv), .convReq(convReq),
        .convRsp(convRsp), .convClkSel(convClkSel), .irq(irq));
    conv_core_model conv_core_model_i (
        .sys_clk(sys_clk), .srst(srst), .convReq(convReq),
        .convRsp(convRsp), .lat(lat), .salt(salt));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge sys_clk);
        busReq.wr <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
        @(posedge sys_clk);
        busReq.rd <= 1'h0;
        #1 d = rdData;
    endtask

    task automatic wait_idle();
        logic [15:0] v;
        for (int i = 0; i < 200; i++) begin
            rd(adc10_pkg::OFF_CSR, v);
            if (v[adc10_pkg::CSR_START_BIT] === 1'h0) return;
        end
        check(16'h0001, 16'h0000, "start bit never cleared");
    endtask

    task automatic pulse(input adc10_pkg::trig_events_t ev);
        @(posedge sys_clk);
        trigEv <= ev;
        @(posedge sys_clk);
        trigEv <= IDLE;
    endtask

    task automatic run_conv(input logic [2:0] ch, input logic scan,
                            input logic ext, input logic ie,
                            input logic [1:0] msk);
        logic [15:0] v;
        logic [3:0] exp[$];
        logic [2:0] ck;
        logic [1:0] md;
        salt <= 6'($urandom);
        lat <= 8'($urandom_range(30));
        reqQ.delete();
        wr(adc10_pkg::OFF_IRQ_MASK, {14'h0000, msk});
        wr(adc10_pkg::OFF_EXT_CTRL, {15'h0000, ext});
        ck = 3'($urandom);
        md = scan ? 2'($urandom_range(3, 1)) : 2'h0;
        wr(adc10_pkg::OFF_CR, {11'h000, ck, md});
        rd(adc10_pkg::OFF_CR, v);
        check(v, {12'h000, ck[1:0], md}, "control read back");
        check(16'(convClkSel), 16'(ck[1:0]), "clock select");
        wr(adc10_pkg::OFF_CSR, {9'h000, ie, 1'h1, 2'h0, ch});
        wait_idle();
        for (int i = scan ? 0 : ch; i <= ch; i++) exp.push_back(4'(i));
        if (ext) exp.push_back(adc10_pkg::EXT_CHAN);
        check(16'(reqQ.size()), 16'(exp.size()), "request count");
        foreach (exp[i]) begin
            check(16'(reqQ[i]), 16'(exp[i]), "channel order");
            rd(exp[i] == adc10_pkg::EXT_CHAN ? adc10_pkg::OFF_RES_EXT
               : adc10_pkg::OFF_RES_A + exp[i], v);
            check(v, {6'h00, salt, exp[i]}, "result register");
        end
        check(16'(irq), 16'(ie & msk[0]), "irq level");
        rd(adc10_pkg::OFF_IRQ_STAT, v);
        check(v, {15'h0000, ie}, "end status");
        rd(adc10_pkg::OFF_IRQ_STAT, v);
        check({v[15:1], irq}, 16'h0000, "status cleared");
    endtask

    task automatic trig_case(input logic [2:0] code);
        adc10_pkg::trig_events_t good, bad;
        logic [15:0] v;
        good = IDLE;
        bad = IDLE;
        case (code)
            3'h1: good.mfTimerCmpA[$urandom_range(4)] = 1'h1;
            3'h2: good.eightTimer0Cmp = 1'h1;
            3'h3: good.extTrigPinN = 1'h0;
            3'h4: good.mfTimerCmpA[0] = 1'h1;
            3'h5: good.puTimerCmpA[$urandom_range(4)] = 1'h1;
            3'h6: good.mfTimer4Cmp = 1'h1;
            default: good.puTimerCmpA[0] = 1'h1;
        endcase
        // neighbours of the chosen source are the likeliest decode slips
        case (code)
            3'h0: bad = 13'h1ffe;
            3'h2: bad.mfTimer4Cmp = 1'h1;
            3'h4: bad.mfTimerCmpA = 5'h1e;
            3'h7: bad.puTimerCmpA = 5'h1e;
            default: bad.eightTimer0Cmp = 1'h1;
        endcase
        lat <= 8'h28;
        // an extended input left enabled would add a second request
        wr(adc10_pkg::OFF_EXT_CTRL, 16'h0000);
        wr(adc10_pkg::OFF_CR, {8'h00, code, 5'h00});
        wr(adc10_pkg::OFF_CSR, 16'h0042);
        reqQ.delete();
        pulse(bad);
        repeat (8) @(posedge sys_clk);
        check(16'(reqQ.size()), 16'h0000, "foreign start");
        if (code != 3'h0) begin
            pulse(good);
            repeat (4) @(posedge sys_clk);
            pulse(good);
            repeat (4) @(posedge sys_clk);
            wait_idle();
            check(16'(reqQ.size()), 16'h0001, "selected start");
            check(16'(reqQ[0]), 16'h0002, "triggered channel");
            rd(adc10_pkg::OFF_IRQ_STAT, v);
            check(v, 16'h0003, "end and lost status");
        end
    endtask

    task automatic reset_reads();
        logic [15:0] v;
        // every index, unmapped ones included, reads zero out of reset
        for (int i = 0; i < 16; i++) begin
            rd(4'(i), v);
            check(v, 16'h0000, "reset read");
        end
        check(16'({convClkSel, irq}), 16'h0000, "reset outputs");
    endtask

    // a zero start write stops a running conversion with no end flag
    task automatic abort_case();
        logic [15:0] v;
        lat <= 8'hc8;
        reqQ.delete();
        wr(adc10_pkg::OFF_CR, 16'h0000);
        wr(adc10_pkg::OFF_CSR, 16'h0065);
        repeat (6) @(posedge sys_clk);
        wr(adc10_pkg::OFF_CSR, 16'h0040);
        rd(adc10_pkg::OFF_CSR, v);
        check(v, 16'h0045, "abort keeps channel, clears start");
        // let the orphaned answer arrive while idle, where it is ignored
        repeat (220) @(posedge sys_clk);
        rd(adc10_pkg::OFF_IRQ_STAT, v);
        check(v, 16'h0000, "abort end status");
        check(16'(reqQ.size()), 16'h0001, "abort requests");
        check(16'(reqQ[0]), 16'h0005, "abort channel");
    endtask

    always @(posedge sys_clk) begin
        if (!srst && convReq.valid === 1'h1) reqQ.push_back(convReq.chan);
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            $display("MISMATCH t=%0t run did not finish", $time);
            close_out();
        end
    end

    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        srst = 1'h1;
        ce = 1'h1;
        busReq = '0;
        trigEv = IDLE;
        lat = 8'h00;
        salt = 6'h00;
        void'($urandom(32'hbf000814));
        repeat (8) @(posedge sys_clk);
        srst <= 1'h0;
        reset_reads();
        $display("test reset done");
        for (int c = 0; c < 8; c++) run_conv(3'(c), 1'h0, 1'h0, 1'h1, 2'h1);
        $display("test single done");
        run_conv(3'h7, 1'h1, 1'h0, 1'h1, 2'h1);
        run_conv(3'h0, 1'h1, 1'h0, 1'h0, 2'h1);
        for (int k = 0; k < 8; k++) begin
            run_conv(3'($urandom), 1'($urandom), 1'($urandom),
                     1'($urandom), 2'($urandom));
        end
        $display("test scan done");
        run_conv(3'h3, 1'h0, 1'h1, 1'h1, 2'h3);
        run_conv(3'h7, 1'h1, 1'h1, 1'h1, 2'h0);
        $display("test extended done");
        for (int k = 0; k < 8; k++) trig_case(3'(k));
        $display("test triggers done");
        abort_case();
        $display("test abort done");
        // reset in mid-run drops a running conversion and every register
        wr(adc10_pkg::OFF_CSR, 16'h0063);
        @(posedge sys_clk);
        srst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'h0;
        reset_reads();
        $display("test mid-run reset done");
        close_out();
    end
endmodule
